// *** shared/smr_pkg.sv ***
// Constants and types for the management-mode resume control block
package smr_pkg;
  // Internal base register value after hardware reset
  localparam logic [31:0] SMR_BASE_RESET = 32'h0003_0000;
  // Handler entry and save-area bounds relative to the base
  localparam logic [31:0] SMR_HANDLER_OFS = 32'h0000_8000;
  localparam logic [31:0] SMR_SAVE_LO_OFS = 32'h0000_fe00;
  localparam logic [31:0] SMR_SAVE_HI_OFS = 32'h0000_ffff;
  // Save-area field offsets relative to base plus handler offset
  localparam logic [31:0] SMR_OFS_BASE_LO = 32'h0000_7ef8;
  localparam logic [31:0] SMR_OFS_BASE_HI = 32'h0000_7efa;
  localparam logic [31:0] SMR_OFS_REV_LO = 32'h0000_7efc;
  localparam logic [31:0] SMR_OFS_REV_HI = 32'h0000_7efe;
  localparam logic [31:0] SMR_OFS_IO = 32'h0000_7f00;
  localparam logic [31:0] SMR_OFS_HALT = 32'h0000_7f02;
  // Field encodings and bit positions
  localparam int SMR_HALT_BIT = 0;
  localparam int SMR_REV_IO_BIT = 16;
  localparam int SMR_REV_RELOC_BIT = 17;
  localparam logic [15:0] SMR_IO_RESTART = 16'h00ff;
  localparam logic [15:0] SMR_IO_NONE = 16'h0000;
  localparam logic [15:0] SMR_HALT_SET = 16'h0001;
  localparam logic [15:0] SMR_HALT_CLR = 16'h0000;
  // Low bits that must be zero for 32-KByte alignment
  localparam logic [31:0] SMR_ALIGN_MASK = 32'h0000_7fff;
  // Base architecture revision; value is arbitrary
  localparam logic [15:0] SMR_REV_BASE = 16'h0001;

  typedef enum logic [1:0] {
    SMR_ST_NORMAL = 2'b00,
    SMR_ST_ENTRY = 2'b01,
    SMR_ST_IN_MM = 2'b10,
    SMR_ST_SHUTDOWN = 2'b11
  } smr_state_t;
endpackage

// *** hw/smr_sync.sv ***
// Two-flop synchroniser for asynchronous input levels
`timescale 1ns/10ps
module smr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** hw/smr_resume_control.sv ***
// Management-mode entry, halt restart, base relocation and I/O restart
// Function
// - Interrupt taken while halted sets halt-restart flag bit 0 at 7F02H.
// - Halt flag still set at resume returns to the halt instruction.
// - Handler-cleared halt flag resumes after the halt instruction.
// - Restarted halt is refetched and issues another halt bus cycle.
// - Halt inside management mode ends only on maskable interrupt, soft init or reset.
// - Base register resets to 30000H, unchanged by soft init.
// - Every resume not ending in shutdown reloads the base register from save-area field 7EF8H.
// - Handler starts at base+8000H; save area base+FE00H to base+FFFFH.
// - Misaligned base at resume causes shutdown where alignment is required.
// - Revision identifier reports base relocation capability.
// - Revision identifier reports I/O-restart capability.
// - I/O-restart field FFH at resume re-executes the trapped I/O instruction.
// - I/O-restart field 00H at resume continues after the I/O instruction.
// - Every entry writes 00H into the I/O-restart field.
// - Core keeps the state needed to re-execute a trapped I/O instruction.
// - A new interrupt pending at resume is serviced before the I/O restart.
// - Revision identifier at 7EFCH; bit 16 I/O restart, bit 17 relocation.
`timescale 1ns/10ps
module smr_resume_control
  import smr_pkg::*;
#(
  parameter bit IO_RESTART_CAP = 1'b1,
  parameter bit RELOC_CAP = 1'b1,
  parameter bit ALIGN_REQUIRED = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic soft_init,
  input wire logic mgmt_interrupt_pin_n,
  input wire logic intr_req_pin,
  input wire logic intr_enable_flag,
  input wire logic halt_exec,
  input wire logic io_boundary,
  input wire logic [31:0] cur_ip,
  input wire logic [31:0] next_ip,
  input wire logic resume_instr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  output logic management_mode,
  output logic core_halted,
  output logic halt_bus_cycle,
  output logic redirect_valid,
  output logic [31:0] redirect_ip,
  output logic halt_refetch,
  output logic shutdown,
  output logic [31:0] mgmt_base,
  output logic [31:0] save_area_lo,
  output logic [31:0] save_area_hi
);
  smr_state_t state_r;
  smr_state_t state_nxt;
  logic [1:0] pin_sync;
  logic smi_level_r;
  logic smi_pending_r;
  logic [31:0] mgmt_base_r;
  logic [31:0] base_field_r;
  logic [15:0] io_field_r;
  logic [15:0] halt_field_r;
  logic halt_entry_r;
  logic [31:0] halt_ip_r;
  logic [31:0] next_ip_r;
  logic [31:0] io_ip_r;
  logic core_halted_r;
  logic redirect_valid_r;
  logic [31:0] redirect_ip_r;
  logic halt_refetch_r;
  logic halt_bus_cycle_r;
  logic [15:0] mem_rdata_r;
  logic mem_ack_r;

  smr_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({intr_req_pin, ~mgmt_interrupt_pin_n}),
    .sync_out(pin_sync)
  );

  // Event decode
  wire smi_level = pin_sync[0];
  wire smi_edge = smi_level && !smi_level_r;
  wire intr_take = pin_sync[1] && intr_enable_flag;
  wire in_normal = state_r == SMR_ST_NORMAL;
  wire in_entry = state_r == SMR_ST_ENTRY;
  wire in_mm = state_r == SMR_ST_IN_MM;
  wire take_entry = in_normal && smi_pending_r && !soft_init;
  wire resume_go = in_mm && resume_instr && !core_halted_r && !soft_init;
  wire back_to_back = resume_go && smi_pending_r;

  // Resume decode
  wire io_restart = IO_RESTART_CAP && (io_field_r == SMR_IO_RESTART);
  wire halt_restart = halt_entry_r && halt_field_r[SMR_HALT_BIT];
  wire misaligned = ALIGN_REQUIRED && ((base_field_r & SMR_ALIGN_MASK) != '0);
  wire [31:0] resume_target = io_restart ? io_ip_r :
                              halt_restart ? halt_ip_r : next_ip_r;

  // Revision identifier
  wire [31:0] rev_id = {14'h0, RELOC_CAP, IO_RESTART_CAP, SMR_REV_BASE};

  // Save-area field decode
  wire [31:0] mem_ofs = mem_addr - mgmt_base_r - SMR_HANDLER_OFS;
  wire mem_wr = mem_req && mem_we && in_mm;
  wire hit_base_lo = mem_ofs == SMR_OFS_BASE_LO;
  wire hit_base_hi = mem_ofs == SMR_OFS_BASE_HI;
  wire hit_rev_lo = mem_ofs == SMR_OFS_REV_LO;
  wire hit_rev_hi = mem_ofs == SMR_OFS_REV_HI;
  wire hit_io = mem_ofs == SMR_OFS_IO;
  wire hit_halt = mem_ofs == SMR_OFS_HALT;
  wire [15:0] mem_rd_mux = hit_base_lo ? base_field_r[15:0] :
                           hit_base_hi ? base_field_r[31:16] :
                           hit_rev_lo ? rev_id[15:0] :
                           hit_rev_hi ? rev_id[31:16] :
                           hit_io ? io_field_r :
                           hit_halt ? halt_field_r : 16'h0000;

  // State transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SMR_ST_NORMAL: begin
        if (take_entry) begin
          state_nxt = SMR_ST_ENTRY;
        end
      end
      SMR_ST_ENTRY: begin
        state_nxt = SMR_ST_IN_MM;
      end
      SMR_ST_IN_MM: begin
        if (resume_go && misaligned) begin
          state_nxt = SMR_ST_SHUTDOWN;
        end else if (back_to_back) begin
          state_nxt = SMR_ST_ENTRY;
        end else if (resume_go) begin
          state_nxt = SMR_ST_NORMAL;
        end
      end
      SMR_ST_SHUTDOWN: begin
        state_nxt = SMR_ST_SHUTDOWN;
      end
    endcase
    if (soft_init) begin
      state_nxt = SMR_ST_NORMAL;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= SMR_ST_NORMAL;
      smi_level_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      smi_level_r <= smi_level;
    end
  end

  // Pending request; a new edge wins over the clear at entry
  always_ff @(posedge clk) begin
    if (!reset_n || soft_init) begin
      smi_pending_r <= 1'b0;
    end else if (smi_edge) begin
      smi_pending_r <= 1'b1;
    end else if (in_entry) begin
      smi_pending_r <= 1'b0;
    end
  end

  // Internal base register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mgmt_base_r <= SMR_BASE_RESET;
    end else if (resume_go && !misaligned) begin
      mgmt_base_r <= base_field_r;
    end
  end

  // Base field in the save area
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      base_field_r <= SMR_BASE_RESET;
    end else if (in_entry) begin
      base_field_r <= mgmt_base_r;
    end else if (mem_wr && hit_base_lo) begin
      base_field_r[15:0] <= mem_wdata;
    end else if (mem_wr && hit_base_hi) begin
      base_field_r[31:16] <= mem_wdata;
    end
  end

  // I/O-restart and halt-restart fields
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      io_field_r <= SMR_IO_NONE;
      halt_field_r <= SMR_HALT_CLR;
      halt_entry_r <= 1'b0;
    end else if (in_entry) begin
      io_field_r <= SMR_IO_NONE;
      halt_field_r <= core_halted_r ? SMR_HALT_SET : SMR_HALT_CLR;
      halt_entry_r <= core_halted_r;
    end else if (mem_wr && hit_io) begin
      io_field_r <= mem_wdata;
    end else if (mem_wr && hit_halt) begin
      halt_field_r <= mem_wdata;
    end
  end

  // Interrupted context kept for resume
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      halt_ip_r <= '0;
      next_ip_r <= '0;
      io_ip_r <= '0;
    end else if (in_normal && halt_exec) begin
      halt_ip_r <= cur_ip;
      next_ip_r <= next_ip;
    end else if (take_entry && !core_halted_r) begin
      next_ip_r <= next_ip;
      if (io_boundary) begin
        io_ip_r <= cur_ip;
      end
    end else if (back_to_back) begin
      next_ip_r <= resume_target;
    end
  end

  // Halt state of the core
  always_ff @(posedge clk) begin
    if (!reset_n || soft_init) begin
      core_halted_r <= 1'b0;
    end else if (halt_exec && (in_normal || in_mm)) begin
      core_halted_r <= 1'b1;
    end else if (intr_take) begin
      core_halted_r <= 1'b0;
    end else if (in_entry) begin
      core_halted_r <= 1'b0;
    end
  end

  // Redirect to handler or resume point
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      redirect_valid_r <= 1'b0;
      redirect_ip_r <= '0;
      halt_refetch_r <= 1'b0;
      halt_bus_cycle_r <= 1'b0;
    end else begin
      redirect_valid_r <= in_entry || (resume_go && !misaligned && !back_to_back);
      halt_refetch_r <= resume_go && !misaligned && !back_to_back &&
                        !io_restart && halt_restart;
      halt_bus_cycle_r <= halt_exec && (in_normal || in_mm) && !soft_init;
      if (in_entry) begin
        redirect_ip_r <= mgmt_base_r + SMR_HANDLER_OFS;
      end else if (resume_go) begin
        redirect_ip_r <= resume_target;
      end
    end
  end

  // Save-area access port
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mem_rdata_r <= 16'h0000;
      mem_ack_r <= 1'b0;
    end else begin
      mem_ack_r <= mem_req;
      mem_rdata_r <= (mem_req && !mem_we) ? mem_rd_mux : 16'h0000;
    end
  end

  assign mem_rdata = mem_rdata_r;
  assign mem_ack = mem_ack_r;
  assign management_mode = in_entry || in_mm;
  assign core_halted = core_halted_r;
  assign halt_bus_cycle = halt_bus_cycle_r;
  assign redirect_valid = redirect_valid_r;
  assign redirect_ip = redirect_ip_r;
  assign halt_refetch = halt_refetch_r;
  assign shutdown = state_r == SMR_ST_SHUTDOWN;
  assign mgmt_base = mgmt_base_r;
  assign save_area_lo = mgmt_base_r + SMR_SAVE_LO_OFS;
  assign save_area_hi = mgmt_base_r + SMR_SAVE_HI_OFS;

  // Checks
  wire resume_ok = resume_go && !misaligned && !back_to_back;

  sequence s_entry_halted;
    in_entry && core_halted_r;
  endsequence

  sequence s_resume_plain;
    resume_ok && !io_restart;
  endsequence

  property p_halt_flag;
    @(posedge clk) disable iff (!reset_n)
      s_entry_halted |=> halt_field_r[SMR_HALT_BIT] && halt_entry_r && !core_halted_r;
  endproperty
  a_halt_flag: assert property (p_halt_flag) else $error("halt flag not set on entry");

  property p_halt_back;
    @(posedge clk) disable iff (!reset_n)
      s_resume_plain and halt_restart |=> redirect_valid && halt_refetch
        && redirect_ip == $past(halt_ip_r);
  endproperty
  a_halt_back: assert property (p_halt_back) else $error("halt restart not taken");

  property p_halt_skip;
    @(posedge clk) disable iff (!reset_n)
      s_resume_plain and !halt_restart |=> redirect_valid && !halt_refetch
        && redirect_ip == $past(next_ip_r);
  endproperty
  a_halt_skip: assert property (p_halt_skip) else $error("resume point wrong");

  property p_mm_halt;
    @(posedge clk) disable iff (!reset_n || soft_init)
      in_mm && core_halted_r && !intr_take |=> core_halted_r;
  endproperty
  a_mm_halt: assert property (p_mm_halt) else $error("left halt without interrupt");

  property p_base_init;
    @(posedge clk) disable iff (!reset_n)
      soft_init |=> mgmt_base_r == $past(mgmt_base_r);
  endproperty
  a_base_init: assert property (p_base_init) else $error("base lost on soft init");

  property p_base_reload;
    @(posedge clk) disable iff (!reset_n)
      resume_go && !misaligned |=> mgmt_base_r == $past(base_field_r);
  endproperty
  a_base_reload: assert property (p_base_reload) else $error("base not reloaded");

  property p_handler_ip;
    @(posedge clk) disable iff (!reset_n)
      in_entry ##1 in_mm |-> redirect_valid && redirect_ip == mgmt_base_r + SMR_HANDLER_OFS;
  endproperty
  a_handler_ip: assert property (p_handler_ip) else $error("handler address wrong");

  property p_shutdown;
    @(posedge clk) disable iff (!reset_n)
      resume_go && misaligned |=> shutdown && !redirect_valid ##1 shutdown || soft_init;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("misaligned base not fatal");

  property p_io_restart;
    @(posedge clk) disable iff (!reset_n)
      resume_ok && io_restart |=> redirect_ip == $past(io_ip_r) && !halt_refetch;
  endproperty
  a_io_restart: assert property (p_io_restart) else $error("I/O not restarted");

  property p_io_clear;
    @(posedge clk) disable iff (!reset_n || soft_init)
      in_entry |=> io_field_r == SMR_IO_NONE && management_mode;
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("I/O field not cleared");

  property p_nested;
    @(posedge clk) disable iff (!reset_n || soft_init)
      back_to_back && !misaligned |=> in_entry ##1 redirect_valid && in_mm;
  endproperty
  a_nested: assert property (p_nested) else $error("pending request not serviced");
endmodule

// *** verification/smr_chipset_model.sv ***
// Chipset model driving the management and maskable interrupt pins
`timescale 1ns/10ps
module smr_chipset_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fire_smi,
  input wire logic fire_irq,
  input wire logic [3:0] hold_len,
  output logic mgmt_interrupt_pin_n,
  output logic intr_req_pin
);
  logic [3:0] smi_cnt_r;
  logic [3:0] irq_cnt_r;
  // Pins idle released; request level held hold_len cycles
  assign mgmt_interrupt_pin_n = (smi_cnt_r == 4'h0);
  assign intr_req_pin = (irq_cnt_r != 4'h0);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      smi_cnt_r <= 4'h0;
      irq_cnt_r <= 4'h0;
    end else begin
      if (fire_smi) begin
        smi_cnt_r <= hold_len;
      end else if (smi_cnt_r != 4'h0) begin
        smi_cnt_r <= smi_cnt_r - 4'h1;
      end
      if (fire_irq) begin
        irq_cnt_r <= hold_len;
      end else if (irq_cnt_r != 4'h0) begin
        irq_cnt_r <= irq_cnt_r - 4'h1;
      end
    end
  end
endmodule

// *** verification/test_smr_resume_control.sv ***
// Self-checking bench for the management-mode resume control
`timescale 1ns/10ps
module test_smr_resume_control
  import smr_pkg::*;
;
  logic clk, reset_n, soft_init, pin_n, irq, ie, halt_exec, io_boundary, resume_instr;
  logic mem_req, mem_we, mem_ack, mm, halted, hbc, rv, refetch, shut, fire_smi, fire_irq;
  logic [31:0] cur_ip, next_ip, mem_addr, rip, base, sa_lo, sa_hi, exp_base;
  logic [15:0] mem_wdata, mem_rdata, rd;
  logic [3:0] hold_len;
  logic shut2, rv2;
  logic [31:0] base2;
  int fail_count = 0;
  int cmp_count = 0;
  smr_resume_control u_dut (.clk(clk), .reset_n(reset_n), .soft_init(soft_init),
    .mgmt_interrupt_pin_n(pin_n), .intr_req_pin(irq), .intr_enable_flag(ie),
    .halt_exec(halt_exec), .io_boundary(io_boundary), .cur_ip(cur_ip), .next_ip(next_ip),
    .resume_instr(resume_instr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .management_mode(mm),
    .core_halted(halted), .halt_bus_cycle(hbc), .redirect_valid(rv), .redirect_ip(rip),
    .halt_refetch(refetch), .shutdown(shut), .mgmt_base(base), .save_area_lo(sa_lo),
    .save_area_hi(sa_hi));
  smr_chipset_model u_chip (.clk(clk), .reset_n(reset_n), .fire_smi(fire_smi),
    .fire_irq(fire_irq), .hold_len(hold_len), .mgmt_interrupt_pin_n(pin_n),
    .intr_req_pin(irq));
  smr_resume_control #(.ALIGN_REQUIRED(1'b1)) u_dut_al (.clk(clk), .reset_n(reset_n),
    .soft_init(soft_init), .mgmt_interrupt_pin_n(pin_n), .intr_req_pin(irq),
    .intr_enable_flag(ie), .halt_exec(halt_exec), .io_boundary(io_boundary), .cur_ip(cur_ip),
    .next_ip(next_ip), .resume_instr(resume_instr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(), .mem_ack(), .management_mode(),
    .core_halted(), .halt_bus_cycle(), .redirect_valid(rv2), .redirect_ip(), .halt_refetch(),
    .shutdown(shut2), .mgmt_base(base2), .save_area_lo(), .save_area_hi());
  always #5 clk = ~clk;
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic mem(input logic we, input logic [31:0] ofs, input logic [15:0] wd);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_addr <= exp_base + SMR_HANDLER_OFS + ofs;
    mem_wdata <= wd;
    @(posedge clk);
    mem_req <= 1'b0;
    #1;
    check("mem_ack", {31'h0, mem_ack}, 32'h1);
    rd = mem_rdata;
  endtask
  task automatic rdchk(input string name, input logic [31:0] ofs, input logic [15:0] exp);
    mem(1'b0, ofs, 16'h0000);
    check(name, {16'h0000, rd}, {16'h0000, exp});
  endtask
  task automatic wait_redirect(input logic [31:0] exp_ip);
    int i;
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      #1;
      if (rv === 1'b1) break;
    end
    if (i == 30) begin
      fail_count++;
      $display("ERROR redirect_valid expected 1 seen timeout");
      conclude();
    end
    check("redirect_ip", rip, exp_ip);
  endtask
  task automatic enter(input logic [3:0] hl);
    @(posedge clk);
    hold_len <= hl;
    fire_smi <= 1'b1;
    @(posedge clk);
    fire_smi <= 1'b0;
    wait_redirect(exp_base + SMR_HANDLER_OFS);
    check("management_mode", {31'h0, mm}, 32'h1);
  endtask
  task automatic resume(input logic [31:0] exp_ip, input logic exp_ref);
    @(posedge clk);
    resume_instr <= 1'b1;
    @(posedge clk);
    resume_instr <= 1'b0;
    #1;
    check("redirect_valid", {31'h0, rv}, 32'h1);
    check("redirect_ip", rip, exp_ip);
    check("halt_refetch", {31'h0, refetch}, {31'h0, exp_ref});
  endtask
  task automatic halt_pulse();
    @(posedge clk);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    #1;
    check("halt_bus_cycle", {31'h0, hbc}, 32'h1);
    check("core_halted", {31'h0, halted}, 32'h1);
  endtask
  task automatic t_reset();
    check("mgmt_base", base, 32'h0003_0000);
    check("save_lo", sa_lo, 32'h0003_fe00);
    check("save_hi", sa_hi, 32'h0003_ffff);
    $display("Test reset done");
  endtask
  task automatic t_reloc();
    enter(4'h4);
    rdchk("io_field", SMR_OFS_IO, 16'h0000);
    rdchk("halt_field", SMR_OFS_HALT, 16'h0000);
    rdchk("rev_lo", SMR_OFS_REV_LO, SMR_REV_BASE);
    rdchk("rev_hi", SMR_OFS_REV_HI, 16'h0003);
    rdchk("base_lo", SMR_OFS_BASE_LO, 16'h0000);
    rdchk("base_hi", SMR_OFS_BASE_HI, 16'h0003);
    mem(1'b1, SMR_OFS_BASE_HI, 16'h0004);
    resume(next_ip, 1'b0);
    exp_base = 32'h0004_0000;
    check("mgmt_base", base, exp_base);
    check("save_lo", sa_lo, 32'h0004_fe00);
    check("save_hi", sa_hi, 32'h0004_ffff);
    @(posedge clk);
    soft_init <= 1'b1;
    @(posedge clk);
    soft_init <= 1'b0;
    @(posedge clk);
    #1;
    check("base_after_init", base, exp_base);
    $display("Test relocation done");
  endtask
  task automatic t_halt();
    halt_pulse();
    enter(4'h9);
    rdchk("halt_field", SMR_OFS_HALT, SMR_HALT_SET);
    resume(cur_ip, 1'b1);
    halt_pulse();
    enter(4'h4);
    mem(1'b1, SMR_OFS_HALT, SMR_HALT_CLR);
    resume(next_ip, 1'b0);
    $display("Test halt restart done");
  endtask
  task automatic t_io();
    @(posedge clk);
    io_boundary <= 1'b1;
    enter(4'h4);
    mem(1'b1, SMR_OFS_IO, SMR_IO_RESTART);
    resume(cur_ip, 1'b0);
    $display("Test io restart done");
  endtask
  task automatic t_b2b();
    int i;
    enter(4'h4);
    mem(1'b1, SMR_OFS_IO, SMR_IO_RESTART);
    @(posedge clk);
    ie <= 1'b1;
    halt_pulse();
    @(posedge clk);
    fire_smi <= 1'b1;
    @(posedge clk);
    fire_smi <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check("halted_on_smi", {31'h0, halted}, 32'h1);
    @(posedge clk);
    fire_irq <= 1'b1;
    @(posedge clk);
    fire_irq <= 1'b0;
    for (i = 0; i < 20 && halted !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    check("halted_on_irq", {31'h0, halted}, 32'h0);
    @(posedge clk);
    resume_instr <= 1'b1;
    @(posedge clk);
    resume_instr <= 1'b0;
    wait_redirect(exp_base + SMR_HANDLER_OFS);
    check("mm_second", {31'h0, mm}, 32'h1);
    rdchk("io_field", SMR_OFS_IO, SMR_IO_NONE);
    mem(1'b1, SMR_OFS_IO, SMR_IO_NONE);
    resume(cur_ip, 1'b0);
    check("shutdown", {31'h0, shut}, 32'h0);
    $display("Test back to back done");
  endtask
  task automatic t_align();
    enter(4'h4);
    mem(1'b1, SMR_OFS_BASE_LO, 16'h1234);
    resume(next_ip, 1'b0);
    check("shutdown_aligned", {31'h0, shut2}, 32'h1);
    check("redirect_aligned", {31'h0, rv2}, 32'h0);
    check("base_aligned", base2, exp_base);
    check("base_free", base, 32'h0004_1234);
    @(posedge clk);
    soft_init <= 1'b1;
    @(posedge clk);
    soft_init <= 1'b0;
    @(posedge clk);
    #1;
    check("shutdown_left", {31'h0, shut2}, 32'h0);
    $display("Test alignment done");
  endtask
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {soft_init, ie, halt_exec, io_boundary, resume_instr, mem_req, mem_we} = 7'h00;
    {fire_smi, fire_irq} = 2'b00;
    hold_len = 4'h4;
    cur_ip = 32'h0000_1000;
    next_ip = 32'h0000_1002;
    mem_addr = 32'h0000_0000;
    mem_wdata = 16'h0000;
    exp_base = SMR_BASE_RESET;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_reloc();
    t_halt();
    t_io();
    t_b2b();
    t_align();
    conclude();
  end
endmodule
